// *** design/led_pin_pkg.sv ***
// Constants, field layout and bus carriers for the LED and upper pin register.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
`default_nettype none
package led_pin_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] CFG_OFFSET = 12'h024;
  localparam int ADDR_W = 12;
  localparam int NPINS = 3;
  // ==========================================================
  // Field positions
  localparam int LED_FUNCTION_SELECT_BIT = 31;
  localparam int PIN10_ROLE_LO = 24;
  localparam int PIN9_ROLE_LO = 20;
  localparam int PIN8_ROLE_LO = 16;
  localparam int DRIVER_LO = 8;
  localparam int DIR_LO = 4;
  localparam int DATA_LO = 0;
  // ==========================================================
  // Reset values
  localparam logic LED_FUNCTION_SELECT_RST = 1'b0;
  localparam logic [1:0] ROLE_RST = 2'h0;
  localparam logic [2:0] DRIVER_RST = 3'h0;
  localparam logic [2:0] DIR_RST = 3'h0;
  localparam logic [2:0] DATA_RST = 3'h0;
  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Pin role codes
  typedef enum logic [1:0] {
    ROLE_GPIO = 2'h0,
    ROLE_LED = 2'h1,
    ROLE_MIRROR_A = 2'h2,
    ROLE_MIRROR_B = 2'h3
  } pin_role_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic speed;
    logic link;
    logic activity;
    logic full_duplex;
  } phy_status_s;

  typedef struct packed {
    logic [3:0] rxd;
    logic crs;
    logic internal_phy_reset_n;
  } mii_mirror_s;
endpackage
`default_nettype wire

// *** design/pin_sync.sv ***
// Two-flop synchroniser for the three upper pin input levels.
// Assumes asynchronous pin levels and the block clock.
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [led_pin_pkg::NPINS-1:0] async_in,
  output logic [led_pin_pkg::NPINS-1:0] sync_out
);
  import led_pin_pkg::*;
  logic [NPINS-1:0] meta_q;

  // First stage is read by the second stage only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** design/led_gpio_pin_config.sv ***
// LED function and upper pin (eight to ten) configuration register with pin muxing.
// Assumes AXI4-Lite master, PHY status and MII mirror inputs on clk, pins asynchronous.
//
// Behaviour
// - Of the three LED pins, bit 31 changes only the link LED.
// - Select zero: duplex LED shows activity.
// - Protected resets keep LED select.
// - No config memory: LED select resets zero.
// - Config memory image loads and restores select.
// - Bits 25:24 choose pin ten role.
// - Bits 21:20 choose pin nine role.
// - Bits 17:16 choose pin eight role.
// - Pin eight/nine LED depends on select.
// - Mirror roles follow internal signal continuously.
// - Bits 6:4 set pin direction.
// - Data bits drive outputs; reads show pins.
// - Data reset value follows pin levels.
`default_nettype none
module led_gpio_pin_config (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Soft resets and configuration image
  input wire logic lite_soft_reset,
  input wire logic usb_soft_reset,
  input wire logic reset_protect,
  input wire logic cfg_mem_present,
  input wire logic cfg_load_done,
  input wire logic cfg_led_select,
  // Register bus
  input wire led_pin_pkg::axil_req_s axil_req,
  output led_pin_pkg::axil_rsp_s axil_rsp,
  // Internal sources
  input wire led_pin_pkg::phy_status_s phy_status,
  input wire led_pin_pkg::mii_mirror_s mii_mirror,
  // LED pins, high means lit
  output logic speed_led_out,
  output logic link_activity_led_out,
  output logic duplex_led_out,
  // Upper pins, index 0 is pin eight
  input wire logic [led_pin_pkg::NPINS-1:0] pin_in,
  output logic [led_pin_pkg::NPINS-1:0] pin_out,
  output logic [led_pin_pkg::NPINS-1:0] pin_oe_n
);
  import led_pin_pkg::*;

  // ==========================================================
  // Register state
  logic led_function_select_q;
  pin_role_e pin10_role_select_q;
  pin_role_e pin9_role_select_q;
  pin_role_e pin8_role_select_q;
  logic [NPINS-1:0] upper_pin_driver_type_q;
  logic [NPINS-1:0] upper_pin_direction_q;
  logic [NPINS-1:0] upper_pin_data_q;
  logic [NPINS-1:0] pin_level;
  logic soft_reset;
  logic [31:0] cfg_word;

  assign soft_reset = lite_soft_reset | usb_soft_reset;

  pin_sync pin_sync_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(pin_in),
    .sync_out(pin_level)
  );

  // ==========================================================
  // AXI4-Lite slave
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic write_hit;
  logic [31:0] wmask;

  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign write_hit = do_write && (awaddr_q[ADDR_W-1:2] == CFG_OFFSET[ADDR_W-1:2]);
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (axil_req.awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      awaddr_q <= axil_req.awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (axil_req.wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      wdata_q <= axil_req.wdata;
      wstrb_q <= axil_req.wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && axil_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Reserved positions stay zero because the word is rebuilt from fields
  assign cfg_word = {led_function_select_q, 5'h00, pin10_role_select_q, 2'h0,
                     pin9_role_select_q, 2'h0, pin8_role_select_q, 5'h00,
                     upper_pin_driver_type_q, 1'b0, upper_pin_direction_q,
                     1'b0, pin_level};

  // Read accepted only while no answer waits, so arready is a plain term
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (axil_req.arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      if (axil_req.araddr[ADDR_W-1:2] == CFG_OFFSET[ADDR_W-1:2]) begin
        rdata_q <= cfg_word;
        rresp_q <= RESP_OKAY;
      end else begin
        rdata_q <= '0;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && axil_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    axil_rsp.awready = !aw_held_q;
    axil_rsp.wready = !w_held_q;
    axil_rsp.bvalid = bvalid_q;
    axil_rsp.bresp = bresp_q;
    axil_rsp.arready = !rvalid_q;
    axil_rsp.rvalid = rvalid_q;
    axil_rsp.rdata = rdata_q;
    axil_rsp.rresp = rresp_q;
  end

  // ==========================================================
  // LED function select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_function_select_q <= LED_FUNCTION_SELECT_RST;
    end else if (write_hit && wstrb_q[3]) begin
      led_function_select_q <= wdata_q[LED_FUNCTION_SELECT_BIT];
    end else if (cfg_load_done && cfg_mem_present) begin
      led_function_select_q <= cfg_led_select;
    end else if (soft_reset && !reset_protect) begin
      led_function_select_q <= cfg_mem_present ? cfg_led_select : LED_FUNCTION_SELECT_RST;
    end
  end

  // ==========================================================
  // Pin configuration fields
  logic [31:0] merged;
  assign merged = (wdata_q & wmask) | (cfg_word & ~wmask);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin10_role_select_q <= pin_role_e'(ROLE_RST);
      pin9_role_select_q <= pin_role_e'(ROLE_RST);
      pin8_role_select_q <= pin_role_e'(ROLE_RST);
    end else if (soft_reset) begin
      pin10_role_select_q <= pin_role_e'(ROLE_RST);
      pin9_role_select_q <= pin_role_e'(ROLE_RST);
      pin8_role_select_q <= pin_role_e'(ROLE_RST);
    end else if (write_hit) begin
      pin10_role_select_q <= pin_role_e'(merged[PIN10_ROLE_LO +: 2]);
      pin9_role_select_q <= pin_role_e'(merged[PIN9_ROLE_LO +: 2]);
      pin8_role_select_q <= pin_role_e'(merged[PIN8_ROLE_LO +: 2]);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper_pin_driver_type_q <= DRIVER_RST;
      upper_pin_direction_q <= DIR_RST;
      upper_pin_data_q <= DATA_RST;
    end else if (soft_reset) begin
      upper_pin_driver_type_q <= DRIVER_RST;
      upper_pin_direction_q <= DIR_RST;
      upper_pin_data_q <= DATA_RST;
    end else if (write_hit) begin
      upper_pin_driver_type_q <= merged[DRIVER_LO +: NPINS];
      upper_pin_direction_q <= merged[DIR_LO +: NPINS];
      // Data lane holds live pin levels, so only written bytes update it
      if (wstrb_q[0]) begin
        upper_pin_data_q <= wdata_q[DATA_LO +: NPINS];
      end
    end
  end

  // ==========================================================
  // LED and pin muxing
  logic led8_src;
  logic led9_src;
  logic [NPINS-1:0] drive_val;
  logic [NPINS-1:0] is_output;
  pin_role_e role [NPINS];

  assign role[0] = pin8_role_select_q;
  assign role[1] = pin9_role_select_q;
  assign role[2] = pin10_role_select_q;
  assign led8_src = led_function_select_q ? phy_status.link : phy_status.full_duplex;
  assign led9_src = led_function_select_q ? phy_status.activity
                  : (phy_status.link & ~phy_status.activity);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_led_out <= 1'b0;
      link_activity_led_out <= 1'b0;
      duplex_led_out <= 1'b0;
    end else begin
      speed_led_out <= phy_status.speed;
      // Activity blinks the link LED off in combined mode
      link_activity_led_out <= led_function_select_q ? phy_status.link
                             : (phy_status.link & ~phy_status.activity);
      duplex_led_out <= phy_status.activity;
    end
  end

  always_comb begin
    drive_val = upper_pin_data_q;
    unique case (pin8_role_select_q)
      ROLE_GPIO: drive_val[0] = upper_pin_data_q[0];
      ROLE_LED: drive_val[0] = led8_src;
      ROLE_MIRROR_A: drive_val[0] = mii_mirror.rxd[2];
      ROLE_MIRROR_B: drive_val[0] = mii_mirror.crs;
    endcase
    unique case (pin9_role_select_q)
      ROLE_GPIO: drive_val[1] = upper_pin_data_q[1];
      ROLE_LED: drive_val[1] = led9_src;
      ROLE_MIRROR_A: drive_val[1] = mii_mirror.rxd[1];
      ROLE_MIRROR_B: drive_val[1] = mii_mirror.internal_phy_reset_n;
    endcase
    unique case (pin10_role_select_q)
      ROLE_GPIO: drive_val[2] = upper_pin_data_q[2];
      ROLE_LED: drive_val[2] = phy_status.speed;
      ROLE_MIRROR_A: drive_val[2] = mii_mirror.rxd[0];
      ROLE_MIRROR_B: drive_val[2] = mii_mirror.rxd[3];
    endcase
  end

  // Any non-GPIO role forces the pin to output
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      assign is_output[gi] = upper_pin_direction_q[gi] || (role[gi] != ROLE_GPIO);
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_out[gi] <= 1'b0;
          pin_oe_n[gi] <= 1'b1;
        end else begin
          pin_out[gi] <= drive_val[gi];
          // Open drain only pulls low; a high level floats to the pull-up
          pin_oe_n[gi] <= !(is_output[gi] && (upper_pin_driver_type_q[gi] || !drive_val[gi]));
        end
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  bresp_unmapped_a: assert property (do_write && !write_hit |=> bvalid_q && bresp_q == RESP_SLVERR)
    else $error("unmapped write not refused");
  reserved_zero_a: assert property (rvalid_q && rresp_q == RESP_OKAY |->
    rdata_q[30:26] == 5'h00 && rdata_q[23:22] == 2'h0 && rdata_q[15:11] == 5'h00
    && rdata_q[7] == 1'b0 && rdata_q[3] == 1'b0)
    else $error("reserved bit read nonzero");
  led_function_select_write_a: assert property (write_hit && wstrb_q[3] |=>
    led_function_select_q == $past(wdata_q[LED_FUNCTION_SELECT_BIT]))
    else $error("led select not written");
  protect_hold_a: assert property (soft_reset && reset_protect && !write_hit && !cfg_load_done
    |=> $stable(led_function_select_q))
    else $error("protected reset changed led select");
  soft_no_mem_a: assert property (soft_reset && !reset_protect && !write_hit && !cfg_mem_present
    |=> !led_function_select_q)
    else $error("led select not cleared without memory");
  image_restore_a: assert property (soft_reset && !reset_protect && !write_hit && cfg_mem_present
    |=> led_function_select_q == $past(cfg_led_select))
    else $error("led select not restored from image");
  duplex_act_a: assert property (##1 duplex_led_out == $past(phy_status.activity))
    else $error("duplex led does not follow activity");
  link_combined_a: assert property (!led_function_select_q ##1 1 |->
    link_activity_led_out == $past(phy_status.link & ~phy_status.activity))
    else $error("combined link led wrong");
  mirror_crs_a: assert property (pin8_role_select_q == ROLE_MIRROR_B |=>
    pin_out[0] == $past(mii_mirror.crs) && (pin_oe_n[0] == !$past(upper_pin_driver_type_q[0]
    || !mii_mirror.crs)))
    else $error("pin eight not mirroring crs");
  input_float_a: assert property (pin9_role_select_q == ROLE_GPIO && !upper_pin_direction_q[1]
    |=> pin_oe_n[1])
    else $error("input pin driven");
  read_live_a: assert property (axil_req.arvalid && !rvalid_q
    && axil_req.araddr[ADDR_W-1:2] == CFG_OFFSET[ADDR_W-1:2]
    |=> rdata_q[2:0] == $past(pin_level))
    else $error("data read not live pin level");
  opendrain_high_a: assert property (is_output[2] && !upper_pin_driver_type_q[2] && drive_val[2]
    |=> pin_oe_n[2])
    else $error("open drain drove high");

  write_cov_c: cover property (write_hit ##[1:4] bvalid_q && axil_req.bready);
  read_cov_c: cover property (axil_req.arvalid && !rvalid_q ##1 rvalid_q);
  mirror_cov_c: cover property (pin10_role_select_q == ROLE_MIRROR_B && pin_out[2]);
  sel_cov_c: cover property (led_function_select_q && soft_reset && reset_protect);
endmodule
`default_nettype wire

// *** dv/pin_partner.sv ***
// Board-side model of the three upper pins and their external drivers.
// Assumes pin_oe_n low while the block drives; a pull-up sits on every pin.
`default_nettype none
module pin_partner (
  // Block side
  input wire logic [led_pin_pkg::NPINS-1:0] pin_out,
  input wire logic [led_pin_pkg::NPINS-1:0] pin_oe_n,
  // Board driver
  input wire logic [led_pin_pkg::NPINS-1:0] ext_en,
  input wire logic [led_pin_pkg::NPINS-1:0] ext_level,
  output logic [led_pin_pkg::NPINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import led_pin_pkg::*;
  // ==========================================================
  // Wire level
  // Pull-up only when nobody drives, so an open-drain high reads as 1
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_level[i];
      end else begin
        pin_in[i] = 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/led_gpio_pin_config_tb_top.sv ***
// Self-checking bench for the LED and upper pin configuration register.
// Assumes AXI4-Lite access at CFG_OFFSET and pins behind pin_partner.
`default_nettype none
module led_gpio_pin_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import led_pin_pkg::*;
  // ==========================================================
  // Wiring
  logic clk, sys_rst, lite_soft_reset, usb_soft_reset, reset_protect;
  logic cfg_mem_present, cfg_load_done, cfg_led_select;
  axil_req_s req;
  axil_rsp_s rsp;
  phy_status_s phy;
  mii_mirror_s mii;
  logic spd_led, lnk_led, dpx_led;
  logic [NPINS-1:0] pin_in, pin_out, pin_oe_n, ext_en, ext_level;
  logic [1:0] resp;
  logic [31:0] rd;
  int num_errors = 0;
  int num_checks = 0;
  localparam logic [3:0] PHY_PAT [3] = '{4'hC, 4'h3, 4'h7};

  led_gpio_pin_config led_gpio_pin_config_i (.clk(clk), .sys_rst(sys_rst),
    .lite_soft_reset(lite_soft_reset), .usb_soft_reset(usb_soft_reset),
    .reset_protect(reset_protect), .cfg_mem_present(cfg_mem_present),
    .cfg_load_done(cfg_load_done), .cfg_led_select(cfg_led_select),
    .axil_req(req), .axil_rsp(rsp), .phy_status(phy), .mii_mirror(mii),
    .speed_led_out(spd_led), .link_activity_led_out(lnk_led), .duplex_led_out(dpx_led),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pin_partner pin_partner_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic timed_out();
    num_errors++;
    $display("BAD %0t bus wait ran out", $time);
    summarize();
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Extra edge at the end keeps two assignments of one strobe out of one step
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bit b = 1'h0;
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'h1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) begin
        req.awvalid <= 1'h0;
      end
      if (req.wvalid && rsp.wready) begin
        req.wvalid <= 1'h0;
      end
      if (rsp.bvalid && req.bready) begin
        resp = rsp.bresp;
        req.bready <= 1'h0;
        b = 1'h1;
      end
    end
    if (!b) begin
      timed_out();
    end
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [11:0] a);
    bit done = 1'h0;
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) begin
        req.arvalid <= 1'h0;
      end
      if (rsp.rvalid && req.rready) begin
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'h0;
        done = 1'h1;
      end
    end
    if (!done) begin
      timed_out();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] d);
    axi_wr(CFG_OFFSET, d, 4'hF);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "write resp");
  endtask

  task automatic rd_chk(input logic [31:0] exp, input string msg);
    axi_rd(CFG_OFFSET);
    chk(rd, exp, msg);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "read resp");
  endtask

  task automatic pulse(input int which);
    case (which)
      0: lite_soft_reset <= 1'h1;
      1: usb_soft_reset <= 1'h1;
      default: cfg_load_done <= 1'h1;
    endcase
    @(posedge clk);
    lite_soft_reset <= 1'h0;
    usb_soft_reset <= 1'h0;
    cfg_load_done <= 1'h0;
    @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(32'h0000_0005, "reset word");
    chk({29'h0, pin_oe_n}, 32'h7, "reset oe");
    $display("test reset done");
  endtask

  task automatic t_pins();
    ext_en <= 3'h0;
    wr(32'h0000_0772);
    settle(4);
    chk({29'h0, pin_out}, 32'h2, "pp out");
    chk({29'h0, pin_oe_n}, 32'h0, "pp oe");
    rd_chk(32'h0000_0772, "pp read");
    wr(32'h0000_0072);
    settle(4);
    chk({29'h0, pin_oe_n}, 32'h2, "od oe");
    rd_chk(32'h0000_0072, "od read");
    wr(32'h0000_0000);
    settle(4);
    rd_chk(32'h0000_0007, "released");
    ext_en <= 3'h7;
    settle(4);
    rd_chk(32'h0000_0005, "input live");
    $display("test pins done");
  endtask

  task automatic t_roles();
    logic [2:0] ep, el;
    logic [31:0] w;
    for (int s = 0; s < 2; s++) begin
      for (int c = 1; c < 4; c++) begin
        w = {s[0], 31'h0} | (c << 24) | (c << 20) | (c << 16) | 32'h700;
        wr(w);
        for (int p = 0; p < 3; p++) begin
          phy <= PHY_PAT[p];
          mii <= (p == 1) ? 6'h2A : 6'h15;
          settle(3);
          el = {phy.speed, s ? phy.link : (phy.link & ~phy.activity), phy.activity};
          case (c)
            1: ep = {phy.speed, s ? phy.activity : (phy.link & ~phy.activity),
                     s ? phy.link : phy.full_duplex};
            2: ep = {mii.rxd[0], mii.rxd[1], mii.rxd[2]};
            default: ep = {mii.rxd[3], mii.internal_phy_reset_n, mii.crs};
          endcase
          chk({29'h0, spd_led, lnk_led, dpx_led}, {29'h0, el}, "leds");
          chk({29'h0, pin_out}, {29'h0, ep}, "role out");
          chk({29'h0, pin_oe_n}, 32'h0, "role oe");
          rd_chk(w | {29'h0, ep}, "role read");
        end
      end
    end
    $display("test roles done");
  endtask

  task automatic t_bus();
    wr(32'h0000_0000);
    axi_wr(12'h028, 32'h8000_0070, 4'hF);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(12'h028);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    rd_chk(32'h0000_0005, "no effect");
    wr(32'h7CC0_F888);
    rd_chk(32'h0000_0005, "reserved");
    axi_wr(CFG_OFFSET, 32'h0000_0777, 4'hE);
    rd_chk(32'h0000_0705, "lane zero off");
    $display("test bus done");
  endtask

  task automatic t_soft();
    wr(32'h8000_0070);
    reset_protect <= 1'h1;
    pulse(0);
    settle(4);
    rd_chk(32'h8000_0005, "protected lite");
    pulse(1);
    rd_chk(32'h8000_0005, "protected usb");
    reset_protect <= 1'h0;
    pulse(0);
    rd_chk(32'h0000_0005, "no memory");
    cfg_mem_present <= 1'h1;
    cfg_led_select <= 1'h1;
    pulse(2);
    rd_chk(32'h8000_0005, "image load");
    wr(32'h0000_0000);
    pulse(1);
    rd_chk(32'h8000_0005, "usb restore");
    wr(32'h0000_0000);
    pulse(0);
    rd_chk(32'h8000_0005, "lite restore");
    $display("test soft resets done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'h1;
    req = '0;
    lite_soft_reset = 1'h0;
    usb_soft_reset = 1'h0;
    reset_protect = 1'h0;
    cfg_mem_present = 1'h0;
    cfg_load_done = 1'h0;
    cfg_led_select = 1'h0;
    phy = '0;
    mii = '0;
    ext_en = 3'h7;
    ext_level = 3'h5;
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    settle(3);
    t_reset();
    t_pins();
    t_roles();
    t_bus();
    t_soft();
    summarize();
  end
endmodule
`default_nettype wire
